// ### pkg/eirq_pkg.sv
// Operation
// RULE_01 - Flag register top two bits read zero
// RULE_02 - Sense bit: zero level, one falling edge
// RULE_03 - Flag set on low level or fall
// RULE_04 - Flag cleared by zero after reading one
// RULE_05 - Level flag auto-clears when pin high, serviced
// RULE_06 - Edge flag auto-clears when serviced
// RULE_07 - Reset and hardware standby clear registers; the code clears sysctl_q on reset only, not on hardware standby
// RULE_08 - Enable bit gates pin request
// RULE_09 - Upper enable and sense bits plain storage
// RULE_10 - Non-maskable request ignores mask bits
// RULE_11 - Edge select picks non-maskable edge
// RULE_12 - Non-maskable vector number seven
// RULE_13 - Pin vectors twelve to seventeen in order
// RULE_14 - Detection independent of pin direction
// RULE_15 - Software sets interrupt pins as plain inputs
// RULE_16 - Only non-maskable, pins 0-2 wake standby
// RULE_17 - Pin priorities from priority register top nibble
// RULE_18 - DMA-steered peripheral requests bypass controller
// RULE_19 - Priority bit to pin mapping
// RULE_20 - Pins synchronised, edges by sample compare
package eirq_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned PIN_N = 6;
    localparam int unsigned REG_W = 8;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ENABLES = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SENSE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PRIO = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_SYSCTL = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
    localparam logic [REG_W-1:0] REG_RESET = 8'h00;
    localparam int unsigned SYS_NMI_EDGE_BIT = 0;
    localparam int unsigned PRIO_PIN0_BIT = 7;
    localparam int unsigned PRIO_PIN1_BIT = 6;
    localparam int unsigned PRIO_PIN23_BIT = 5;
    localparam int unsigned PRIO_PIN45_BIT = 4;
    localparam int unsigned WAKE_PIN_N = 3;
    localparam logic [7:0] VEC_NMI = 8'h07;
    localparam logic [7:0] VEC_PIN_BASE = 8'h0C;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic HRESP_OKAY = 1'b0;
endpackage

// ### hdl/eirq_top.sv
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module eirq_top
    import eirq_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [ADDR_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [DATA_W-1:0] hwdata_i,
    input wire logic hready_i,
    output logic [DATA_W-1:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [PIN_N-1:0] ext_req_n_i,
    input wire logic nmi_pin_i,
    input wire logic hw_standby_i,
    input wire logic sw_standby_i,
    input wire logic irq_mask_i,
    input wire logic user_mask_i,
    input wire logic ack_valid_i,
    input wire logic [7:0] ack_vector_i,
    input wire logic [1:0] periph_req_i,
    input wire logic [1:0] periph_dma_sel_i,
    output logic req_valid_o,
    output logic [7:0] req_vector_o,
    output logic req_high_prio_o,
    output logic [PIN_N-1:0] pin_req_o,
    output logic nmi_req_o,
    output logic wake_o,
    output logic [1:0] periph_irq_o,
    output logic [1:0] dma_start_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [PIN_N-1:0] pin_s1_q;
    logic [PIN_N-1:0] pin_s2_q;
    logic [PIN_N-1:0] pin_prev_q;
    logic nmi_s1_q;
    logic nmi_s2_q;
    logic nmi_prev_q;
    logic [REG_W-1:0] flags_q;
    logic [REG_W-1:0] enables_q;
    logic [REG_W-1:0] sense_q;
    logic [REG_W-1:0] prio_q;
    logic [REG_W-1:0] sysctl_q;
    logic [PIN_N-1:0] armed_q;
    logic nmi_pend_q;
    logic wr_pend_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic rd_pend_q;
    logic [ADDR_W-1:0] rd_addr_q;
    logic [DATA_W-1:0] hrdata_q;
    logic hreadyout_q;
    logic req_valid_q;
    logic [7:0] req_vector_q;
    logic req_high_q;
    logic [PIN_N-1:0] pin_req_q;
    logic wake_q;
    logic [1:0] periph_irq_q;
    logic [1:0] dma_start_q;
    logic take;
    logic clr_all;
    logic wr_flags;
    logic [PIN_N-1:0] set_d;
    logic [PIN_N-1:0] svc_clr_d;
    logic [PIN_N-1:0] sw_clr_d;
    logic [PIN_N-1:0] pin_prio;
    logic [PIN_N-1:0] active;
    logic nmi_edge;
    logic [REG_W-1:0] rd_byte;
    logic sel_valid;
    logic [7:0] sel_vector;
    logic sel_high;

    assign take = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
    // RULE_07 clear on standby
    assign clr_all = !nrst_i || hw_standby_i;
    assign wr_flags = wr_pend_q && (wr_addr_q == OFS_FLAGS);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    // RULE_20 two flop sync
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            pin_s1_q <= '1;
            pin_s2_q <= '1;
            pin_prev_q <= '1;
            nmi_s1_q <= 1'b0;
            nmi_s2_q <= 1'b0;
            nmi_prev_q <= 1'b0;
        end
        else
        begin
            pin_s1_q <= ext_req_n_i;
            pin_s2_q <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
            nmi_s1_q <= nmi_pin_i;
            nmi_s2_q <= nmi_s1_q;
            nmi_prev_q <= nmi_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag set and clear terms
    always_comb
    begin
        set_d = '0;
        svc_clr_d = '0;
        sw_clr_d = '0;
        for (int i = 0; i < PIN_N; i++)
        begin
            // RULE_02 RULE_03 RULE_14 level or fall
            if (sense_q[i])
            begin
                set_d[i] = pin_prev_q[i] && !pin_s2_q[i];
            end
            else
            begin
                set_d[i] = !pin_s2_q[i];
            end
            // RULE_05 RULE_06 RULE_13 service clear
            if (ack_valid_i && (ack_vector_i == VEC_PIN_BASE + 8'(i)))
            begin
                svc_clr_d[i] = sense_q[i] || pin_s2_q[i];
            end
            // RULE_04 zero after read
            sw_clr_d[i] = wr_flags && !hwdata_i[i] && armed_q[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request flag register
    // RULE_01 upper bits held zero
    always_ff @(posedge clk_i)
    begin
        if (clr_all)
        begin
            flags_q <= REG_RESET;
        end
        else
        begin
            flags_q[PIN_N-1:0] <= set_d | (flags_q[PIN_N-1:0] & ~(svc_clr_d | sw_clr_d));
        end
    end

    // RULE_04 read arms the clear
    always_ff @(posedge clk_i)
    begin
        if (clr_all)
        begin
            armed_q <= '0;
        end
        else if (rd_pend_q && (rd_addr_q == OFS_FLAGS))
        begin
            armed_q <= armed_q | flags_q[PIN_N-1:0];
        end
        else
        begin
            armed_q <= armed_q & flags_q[PIN_N-1:0] & ~sw_clr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Writable control registers
    // RULE_07 RULE_09 full byte storage
    always_ff @(posedge clk_i)
    begin
        if (clr_all)
        begin
            enables_q <= REG_RESET;
            sense_q <= REG_RESET;
            prio_q <= REG_RESET;
        end
        else if (wr_pend_q)
        begin
            if (wr_addr_q == OFS_ENABLES)
            begin
                enables_q <= hwdata_i[REG_W-1:0];
            end
            if (wr_addr_q == OFS_SENSE)
            begin
                sense_q <= hwdata_i[REG_W-1:0];
            end
            if (wr_addr_q == OFS_PRIO)
            begin
                prio_q <= hwdata_i[REG_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            sysctl_q <= REG_RESET;
        end
        else if (wr_pend_q && (wr_addr_q == OFS_SYSCTL))
        begin
            sysctl_q <= hwdata_i[REG_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Non-maskable request
    // RULE_11 edge select
    assign nmi_edge = sysctl_q[SYS_NMI_EDGE_BIT] ? (nmi_s2_q && !nmi_prev_q)
                                                  : (!nmi_s2_q && nmi_prev_q);

    // RULE_12 cleared on vector seven
    always_ff @(posedge clk_i)
    begin
        if (clr_all)
        begin
            nmi_pend_q <= 1'b0;
        end
        else if (nmi_edge)
        begin
            nmi_pend_q <= 1'b1;
        end
        else if (ack_valid_i && (ack_vector_i == VEC_NMI))
        begin
            nmi_pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Priority and vector selection
    // RULE_17 RULE_19 priority mapping
    assign pin_prio = {prio_q[PRIO_PIN45_BIT], prio_q[PRIO_PIN45_BIT],
                       prio_q[PRIO_PIN23_BIT], prio_q[PRIO_PIN23_BIT],
                       prio_q[PRIO_PIN1_BIT], prio_q[PRIO_PIN0_BIT]};
    // RULE_08 enable gating
    assign active = flags_q[PIN_N-1:0] & enables_q[PIN_N-1:0];

    always_comb
    begin
        sel_valid = 1'b0;
        sel_vector = '0;
        sel_high = 1'b0;
        // RULE_10 mask bits ignored
        if (nmi_pend_q)
        begin
            sel_valid = 1'b1;
            sel_vector = VEC_NMI;
            sel_high = 1'b1;
        end
        else if (!irq_mask_i && !user_mask_i)
        begin
            for (int i = PIN_N - 1; i >= 0; i--)
            begin
                if (active[i] && !pin_prio[i])
                begin
                    sel_valid = 1'b1;
                    sel_vector = VEC_PIN_BASE + 8'(i);
                    sel_high = 1'b0;
                end
            end
            for (int i = PIN_N - 1; i >= 0; i--)
            begin
                if (active[i] && pin_prio[i])
                begin
                    sel_valid = 1'b1;
                    sel_vector = VEC_PIN_BASE + 8'(i);
                    sel_high = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (clr_all)
        begin
            req_valid_q <= 1'b0;
            req_vector_q <= '0;
            req_high_q <= 1'b0;
            pin_req_q <= '0;
        end
        else
        begin
            req_valid_q <= sel_valid;
            req_vector_q <= sel_vector;
            req_high_q <= sel_high;
            pin_req_q <= active;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Standby wake
    // RULE_16 limited wake sources
    always_ff @(posedge clk_i)
    begin
        if (clr_all)
        begin
            wake_q <= 1'b0;
        end
        else
        begin
            wake_q <= sw_standby_i && (nmi_pend_q || (|active[WAKE_PIN_N-1:0]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Peripheral steering
    // RULE_18 DMA bypass
    always_ff @(posedge clk_i)
    begin
        if (clr_all)
        begin
            periph_irq_q <= '0;
            dma_start_q <= '0;
        end
        else
        begin
            periph_irq_q <= periph_req_i & ~periph_dma_sel_i;
            dma_start_q <= periph_req_i & periph_dma_sel_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            rd_pend_q <= 1'b0;
            rd_addr_q <= '0;
            hreadyout_q <= 1'b1;
        end
        else
        begin
            wr_pend_q <= take && hwrite_i;
            rd_pend_q <= take && !hwrite_i;
            if (take)
            begin
                wr_addr_q <= {haddr_i[ADDR_W-1:2], 2'b00};
                rd_addr_q <= {haddr_i[ADDR_W-1:2], 2'b00};
            end
            hreadyout_q <= !(take && !hwrite_i);
        end
    end

    always_comb
    begin
        rd_byte = '0;
        unique case (rd_addr_q)
            OFS_FLAGS: rd_byte = {2'b00, flags_q[PIN_N-1:0]};
            OFS_ENABLES: rd_byte = enables_q;
            OFS_SENSE: rd_byte = sense_q;
            OFS_PRIO: rd_byte = prio_q;
            OFS_SYSCTL: rd_byte = sysctl_q;
            OFS_STATUS: rd_byte = {1'b0, nmi_pend_q, pin_s2_q};
            default: rd_byte = '0;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            hrdata_q <= '0;
        end
        else if (rd_pend_q)
        begin
            hrdata_q <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
        end
    end

    assign hrdata_o = hrdata_q;
    assign hreadyout_o = hreadyout_q;
    assign hresp_o = HRESP_OKAY;
    assign req_valid_o = req_valid_q;
    assign req_vector_o = req_vector_q;
    assign req_high_prio_o = req_high_q;
    assign pin_req_o = pin_req_q;
    assign nmi_req_o = nmi_pend_q;
    assign wake_o = wake_q;
    assign periph_irq_o = periph_irq_q;
    assign dma_start_o = dma_start_q;

endmodule

// ### verif/eirq_properties.sv
`timescale 1ns/1ps
module eirq_properties
    import eirq_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic hw_standby_i,
    input wire logic sw_standby_i,
    input wire logic [1:0] periph_req_i,
    input wire logic [1:0] periph_dma_sel_i,
    input wire logic req_valid_o,
    input wire logic [7:0] req_vector_o,
    input wire logic req_high_prio_o,
    input wire logic [PIN_N-1:0] pin_req_o,
    input wire logic nmi_req_o,
    input wire logic wake_o,
    input wire logic [1:0] periph_irq_o,
    input wire logic [1:0] dma_start_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////////
    a_standby_clear: assert property (
        hw_standby_i |=> pin_req_o == 6'h00 && !nmi_req_o)
        else $error("standby left a request");
    a_dma_steer: assert property (
        $past(nrst_i) && !$past(hw_standby_i)
        |-> dma_start_o == $past(periph_req_i & periph_dma_sel_i))
        else $error("dma start wrong");
    a_periph_bypass: assert property (
        $past(nrst_i) && !$past(hw_standby_i)
        |-> periph_irq_o == $past(periph_req_i & ~periph_dma_sel_i))
        else $error("peripheral request wrong");
    a_nmi_accept: assert property (
        nmi_req_o && !hw_standby_i |=> req_valid_o && req_high_prio_o)
        else $error("nmi not accepted");
    a_nmi_vector: assert property (
        nmi_req_o && !hw_standby_i |=> req_vector_o == 8'h07)
        else $error("nmi vector wrong");
    a_pin_vector: assert property (
        req_valid_o && !$past(nmi_req_o) |-> req_vector_o inside {[8'h0C:8'h11]}
        && pin_req_o[req_vector_o - 8'h0C] == 1'b1)
        else $error("pin vector wrong");
    a_wake_gate: assert property (
        wake_o |-> $past(sw_standby_i))
        else $error("wake outside standby");
    a_wake_source: assert property (
        wake_o |-> $past(nmi_req_o) || pin_req_o[2:0] != 3'h0)
        else $error("wake from wrong source");
endmodule

// ### verif/eirq_pin_model.sv
`timescale 1ns/1ps
module eirq_pin_model
    import eirq_pkg::*;
(
    input wire logic clk_i,
    output logic [PIN_N-1:0] ext_req_n_o,
    output logic nmi_pin_o,
    output logic ack_valid_o,
    output logic [7:0] ack_vector_o
);
    initial
    begin
        ext_req_n_o = 6'h3F;
        nmi_pin_o = 1'b0;
        ack_valid_o = 1'b0;
        ack_vector_o = 8'h00;
    end
    task automatic pin(input int k, input logic v);
        @(posedge clk_i);
        ext_req_n_o[k] <= v;
    endtask
    task automatic nmi(input logic v);
        @(posedge clk_i);
        nmi_pin_o <= v;
    endtask
    // One-cycle exception handling pulse
    task automatic ack(input logic [7:0] v);
        @(posedge clk_i);
        ack_valid_o <= 1'b1;
        ack_vector_o <= v;
        @(posedge clk_i);
        ack_valid_o <= 1'b0;
    endtask
endmodule

// ### verif/eirq_top_tb.sv
`timescale 1ns/1ps
module eirq_top_tb;
    import eirq_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic hsel_i = 1'b1;
    logic [ADDR_W-1:0] haddr_i = 8'h00;
    logic [1:0] htrans_i = 2'b00;
    logic hwrite_i = 1'b0;
    logic [2:0] hsize_i = 3'h2;
    logic [DATA_W-1:0] hwdata_i = 32'h0;
    logic [DATA_W-1:0] hrdata_o;
    logic hreadyout_o, hresp_o, nmi_pin_i, ack_valid_i, req_valid_o, req_high_prio_o;
    logic nmi_req_o, wake_o;
    logic hw_standby_i = 1'b0;
    logic sw_standby_i = 1'b0;
    logic irq_mask_i = 1'b0;
    logic user_mask_i = 1'b0;
    logic [1:0] periph_req_i = 2'b00;
    logic [1:0] periph_dma_sel_i = 2'b00;
    logic [1:0] periph_irq_o, dma_start_o;
    logic [PIN_N-1:0] ext_req_n_i, pin_req_o;
    logic [7:0] ack_vector_i, req_vector_o;
    wire hready_i = hreadyout_o;
    int n_errors = 0;
    int compares = 0;
    eirq_top u_eirq_top (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hwdata_i(hwdata_i),
        .hready_i(hready_i),
        .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .ext_req_n_i(ext_req_n_i),
        .nmi_pin_i(nmi_pin_i),
        .hw_standby_i(hw_standby_i),
        .sw_standby_i(sw_standby_i),
        .irq_mask_i(irq_mask_i),
        .user_mask_i(user_mask_i),
        .ack_valid_i(ack_valid_i),
        .ack_vector_i(ack_vector_i),
        .periph_req_i(periph_req_i),
        .periph_dma_sel_i(periph_dma_sel_i),
        .req_valid_o(req_valid_o),
        .req_vector_o(req_vector_o),
        .req_high_prio_o(req_high_prio_o),
        .pin_req_o(pin_req_o),
        .nmi_req_o(nmi_req_o),
        .wake_o(wake_o),
        .periph_irq_o(periph_irq_o),
        .dma_start_o(dma_start_o)
    );
    eirq_pin_model u_eirq_pin_model (
        .clk_i(clk_i),
        .ext_req_n_o(ext_req_n_i),
        .nmi_pin_o(nmi_pin_i),
        .ack_valid_o(ack_valid_i),
        .ack_vector_o(ack_vector_i)
    );
    initial forever #2.5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wait_rdy;
        int i;
        @(posedge clk_i);
        for (i = 0; i < 50 && hreadyout_o !== 1'b1; i++)
            @(posedge clk_i);
        if (i == 50)
        begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    // Address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        htrans_i <= HTRANS_NONSEQ;
        hwrite_i <= w;
        haddr_i <= a;
        wait_rdy();
        htrans_i <= 2'b00;
        hwdata_i <= d;
        wait_rdy();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(hrdata_o, e);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rdc(OFS_FLAGS, 32'h0);
        rdc(OFS_ENABLES, 32'h0);
        rdc(OFS_SENSE, 32'h0);
        rdc(8'h40, 32'h0);
        wr(OFS_ENABLES, 32'hC0);
        rdc(OFS_ENABLES, 32'hC0);
        wr(OFS_SENSE, 32'hC0);
        rdc(OFS_SENSE, 32'hC0);
        wr(OFS_FLAGS, 32'hFF);
        rdc(OFS_FLAGS, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_level;
        u_eirq_pin_model.pin(0, 1'b0);
        cyc(6);
        chk(pin_req_o, 32'h0);
        rdc(OFS_FLAGS, 32'h1);
        wr(OFS_ENABLES, 32'hC1);
        cyc(4);
        chk(req_vector_o, 32'hC);
        u_eirq_pin_model.pin(0, 1'b1);
        cyc(4);
        rdc(OFS_FLAGS, 32'h1);
        u_eirq_pin_model.ack(8'h0C);
        cyc(3);
        rdc(OFS_FLAGS, 32'h0);
        $display("test level done");
    endtask
    task automatic t_edge;
        wr(OFS_SENSE, 32'hC8);
        wr(OFS_ENABLES, 32'hC8);
        u_eirq_pin_model.pin(3, 1'b0);
        cyc(6);
        rdc(OFS_FLAGS, 32'h8);
        wr(OFS_FLAGS, 32'hFF);
        rdc(OFS_FLAGS, 32'h8);
        wr(OFS_FLAGS, 32'h0);
        rdc(OFS_FLAGS, 32'h0);
        u_eirq_pin_model.pin(3, 1'b1);
        cyc(3);
        u_eirq_pin_model.pin(3, 1'b0);
        cyc(6);
        chk(req_vector_o, 32'hF);
        u_eirq_pin_model.ack(8'h0F);
        cyc(3);
        rdc(OFS_FLAGS, 32'h0);
        u_eirq_pin_model.pin(3, 1'b1);
        $display("test edge done");
    endtask
    task automatic t_nmi;
        irq_mask_i <= 1'b1;
        user_mask_i <= 1'b1;
        wr(OFS_SYSCTL, 32'h1);
        u_eirq_pin_model.nmi(1'b1);
        cyc(6);
        chk(nmi_req_o, 32'h1);
        chk(req_vector_o, 32'h7);
        u_eirq_pin_model.ack(8'h07);
        cyc(3);
        chk(nmi_req_o, 32'h0);
        u_eirq_pin_model.nmi(1'b0);
        cyc(6);
        chk(nmi_req_o, 32'h0);
        wr(OFS_SYSCTL, 32'h0);
        u_eirq_pin_model.nmi(1'b1);
        cyc(6);
        chk(nmi_req_o, 32'h0);
        u_eirq_pin_model.nmi(1'b0);
        cyc(6);
        chk(nmi_req_o, 32'h1);
        chk(req_vector_o, 32'h7);
        u_eirq_pin_model.ack(8'h07);
        cyc(3);
        chk(nmi_req_o, 32'h0);
        irq_mask_i <= 1'b0;
        user_mask_i <= 1'b0;
        periph_req_i <= 2'b11;
        periph_dma_sel_i <= 2'b01;
        cyc(2);
        chk(dma_start_o, 32'h1);
        chk(periph_irq_o, 32'h2);
        periph_req_i <= 2'b00;
        $display("test nmi done");
    endtask
    task automatic t_prio;
        wr(OFS_SENSE, 32'h0);
        wr(OFS_ENABLES, 32'h3F);
        u_eirq_pin_model.pin(0, 1'b0);
        u_eirq_pin_model.pin(4, 1'b0);
        cyc(6);
        chk(req_vector_o, 32'hC);
        chk(req_high_prio_o, 32'h0);
        wr(OFS_PRIO, 32'h10);
        cyc(3);
        chk(req_vector_o, 32'h10);
        chk(req_high_prio_o, 32'h1);
        wr(OFS_PRIO, 32'h80);
        cyc(3);
        chk(req_vector_o, 32'hC);
        chk(req_high_prio_o, 32'h1);
        u_eirq_pin_model.pin(0, 1'b1);
        u_eirq_pin_model.pin(4, 1'b1);
        cyc(3);
        u_eirq_pin_model.ack(8'h0C);
        u_eirq_pin_model.ack(8'h10);
        cyc(3);
        rdc(OFS_FLAGS, 32'h0);
        wr(OFS_PRIO, 32'h0);
        $display("test prio done");
    endtask
    task automatic t_standby;
        wr(OFS_SENSE, 32'h0);
        wr(OFS_ENABLES, 32'h3F);
        sw_standby_i <= 1'b1;
        u_eirq_pin_model.pin(4, 1'b0);
        cyc(6);
        chk(wake_o, 32'h0);
        u_eirq_pin_model.pin(1, 1'b0);
        cyc(6);
        chk(wake_o, 32'h1);
        hw_standby_i <= 1'b1;
        cyc(2);
        hw_standby_i <= 1'b0;
        rdc(OFS_ENABLES, 32'h0);
        rdc(OFS_SENSE, 32'h0);
        sw_standby_i <= 1'b0;
        $display("test standby done");
    endtask
    initial
    begin
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_regs();
        t_level();
        t_edge();
        t_nmi();
        t_prio();
        t_standby();
        tally_and_finish();
    end
endmodule
bind eirq_top eirq_properties u_eirq_properties (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .hw_standby_i(hw_standby_i),
    .sw_standby_i(sw_standby_i),
    .periph_req_i(periph_req_i),
    .periph_dma_sel_i(periph_dma_sel_i),
    .req_valid_o(req_valid_o),
    .req_vector_o(req_vector_o),
    .req_high_prio_o(req_high_prio_o),
    .pin_req_o(pin_req_o),
    .nmi_req_o(nmi_req_o),
    .wake_o(wake_o),
    .periph_irq_o(periph_irq_o),
    .dma_start_o(dma_start_o)
);
